// >>> include/i2c_irq_pkg.sv
// Constants shared by the I2C interrupt, vector and target address logic
// Contract
// - The target address register holds a right-justified 10-bit address, bit 9 the MSB, bits 15..10 read zero.
// - The target address is used only in master mode and has no effect on the bus in slave mode.
// - The enable register holds eight enables reset to zero, start detect at bit 7 down to arbitration lost at bit 0.
// - While transmit DMA servicing is on, the transmit-ready enable is ignored and that flag raises no request.
// - While receive DMA servicing is on, the receive-ready enable is ignored and that flag raises no request.
// - The flag register holds eight read/write pending flags reset to zero, in the same order as the enables.
// - Master transmitter with byte counting sets access ready once the programmed byte count is sent.
// - Master transmitter in repeat mode sets access ready when the last byte is sent after a stop request.
// - Master receiver with byte counting sets access ready when the count is received and the buffer is empty.
// - Master receiver in repeat mode sets access ready after the last byte, stop request and an empty buffer.
// - As slave, access ready sets on a received stop; when receiving it also waits for an empty buffer.
// - The vector reports the top pending source in bits 4..1, codes 0 for none and 2..16 from arbitration lost down.
// - With repeat mode off the byte count sets the master transfer length; with it on the count is unused.
// - Setting the stop request makes the device send a stop, and the bit clears itself once the stop is done.
package i2c_irq_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int NUM_EVENTS = 8;
	localparam int TARGET_W = 10;
	localparam int COUNT_W = 8;
	// Register offsets
	localparam logic [3:0] OFS_TARGET = 4'h0;
	localparam logic [3:0] OFS_ENABLE = 4'h1;
	localparam logic [3:0] OFS_FLAGS = 4'h2;
	localparam logic [3:0] OFS_VECTOR = 4'h3;
	localparam logic [3:0] OFS_CONTROL = 4'h4;
	localparam logic [3:0] OFS_COUNT = 4'h5;
	localparam logic [3:0] OFS_STATUS = 4'h6;
	// Event bit positions, shared by enables and flags
	localparam int BIT_START = 7;
	localparam int BIT_GCALL = 6;
	localparam int BIT_TXRDY = 5;
	localparam int BIT_RXRDY = 4;
	localparam int BIT_ARDY = 3;
	localparam int BIT_OWN = 2;
	localparam int BIT_NACK = 1;
	localparam int BIT_ARB = 0;
	// Control register fields
	localparam int CTL_STOP = 0;
	localparam int CTL_REPEAT = 1;
	localparam int CTL_TXDMA = 2;
	localparam int CTL_RXDMA = 3;
	// Vector field position and code layout
	localparam int VEC_LSB = 1;
	localparam logic [3:0] VEC_NONE = 4'h0;
	// Reset values
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [9:0] TARGET_RESET = 10'h000;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [15:0] RDATA_RESET = 16'h0000;
endpackage

// >>> hw/event_vector_encoder.sv
// Priority encoder from pending flags to the vector field and the reported flag
module event_vector_encoder
	import i2c_irq_pkg::*;
(
	// Pending flags
	input wire logic [7:0] flags_i,
	// Vector field (bits 4..1) and one-hot of the reported flag
	output logic [3:0] code_o,
	output logic [7:0] onehot_o
);
	// Walk from lowest priority up so the lowest set bit wins
	always_comb begin
		code_o = VEC_NONE;
		onehot_o = 8'h00;
		for (int i = NUM_EVENTS - 1; i >= 0; i--) begin
			if (flags_i[i]) begin
				code_o = 4'(i + 1);
				onehot_o = 8'(1 << i);
			end
		end
	end
endmodule

// >>> hw/access_ready_detect.sv
// Access ready event generation for master and slave transfers
module access_ready_detect
	import i2c_irq_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// Transfer context
	input wire logic master_i,
	input wire logic transmit_i,
	input wire logic repeat_mode_i,
	input wire logic stop_request_i,
	input wire logic [7:0] byte_count_i,
	// Engine events
	input wire logic master_start_i,
	input wire logic byte_done_i,
	input wire logic stop_received_i,
	input wire logic rx_buffer_empty_i,
	// Results
	output logic access_ready_o,
	output logic [7:0] bytes_moved_o
);
	typedef struct packed {
		logic [7:0] count;
		logic wait_rx;
		logic fire;
	} ardy_state_type;

	ardy_state_type state, next_state;
	logic [7:0] count_inc;
	logic last_byte;

	assign count_inc = state.count + 8'h01;
	assign access_ready_o = state.fire;
	assign bytes_moved_o = state.count;

	always_comb begin
		next_state = state;
		next_state.fire = 1'b0;
		last_byte = 1'b0;
		if (master_start_i) begin
			next_state.count = COUNT_RESET;
			next_state.wait_rx = 1'b0;
		end else if (master_i && byte_done_i) begin
			next_state.count = count_inc;
			if (repeat_mode_i)
				last_byte = stop_request_i;
			else
				last_byte = (count_inc == byte_count_i);
		end
		if (master_i && last_byte) begin
			if (transmit_i)
				next_state.fire = 1'b1;
			else
				next_state.wait_rx = 1'b1;
		end
		if (!master_i && stop_received_i) begin
			if (transmit_i)
				next_state.fire = 1'b1;
			else
				next_state.wait_rx = 1'b1;
		end
		// Receive side holds off until software has drained the buffer
		if (state.wait_rx && rx_buffer_empty_i) begin
			next_state.wait_rx = 1'b0;
			next_state.fire = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i)
			state <= '0;
		else
			state <= next_state;
	end

	a_count_fire: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		master_i && transmit_i && !repeat_mode_i && byte_done_i && !master_start_i
		&& count_inc == byte_count_i |=> access_ready_o)
		else $error("access ready missing after counted transmit");
endmodule

// >>> hw/i2c_interrupt_vector_logic.sv
// Interrupt enables, flags, prioritised vector and target address of the I2C controller
//
// The implementer's own choices: the register offsets and the strobed register port.
module i2c_interrupt_vector_logic
	import i2c_irq_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// Register port
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	// Event pulses from the shift engine
	input wire logic start_detect_i,
	input wire logic general_call_i,
	input wire logic tx_ready_i,
	input wire logic rx_ready_i,
	input wire logic own_address_i,
	input wire logic no_ack_i,
	input wire logic arb_lost_i,
	// Transfer progress from the shift engine
	input wire logic master_start_i,
	input wire logic byte_done_i,
	input wire logic stop_done_i,
	input wire logic stop_received_i,
	input wire logic rx_buffer_empty_i,
	input wire logic master_i,
	input wire logic transmit_i,
	// To the shift engine and the processor
	output logic [9:0] target_address_o,
	output logic stop_request_o,
	output logic irq_o
);
	typedef struct packed {
		logic [9:0] target_addr;
		logic [7:0] enable;
		logic [7:0] flags;
		logic stop_req;
		logic repeat_mode;
		logic tx_dma;
		logic rx_dma;
		logic [7:0] byte_count;
		logic [15:0] rdata;
		logic irq;
		logic [9:0] target_out;
	} regs_state_type;

	regs_state_type state, next_state;

	logic access_ready;
	logic [7:0] bytes_moved;
	logic [3:0] vec_code;
	logic [7:0] vec_onehot;
	logic [7:0] events;
	logic [7:0] eff_enable;
	logic [7:0] next_eff_enable;
	logic wr_ctrl;
	logic rd_vec;

	////////////////////////////////////////////////////////////////////////////
	// Sub-blocks

	access_ready_detect u_ardy (
		.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.master_i(master_i),
		.transmit_i(transmit_i),
		.repeat_mode_i(state.repeat_mode),
		.stop_request_i(state.stop_req),
		.byte_count_i(state.byte_count),
		.master_start_i(master_start_i),
		.byte_done_i(byte_done_i),
		.stop_received_i(stop_received_i),
		.rx_buffer_empty_i(rx_buffer_empty_i),
		.access_ready_o(access_ready),
		.bytes_moved_o(bytes_moved)
	);

	event_vector_encoder u_vec (
		.flags_i(state.flags),
		.code_o(vec_code),
		.onehot_o(vec_onehot)
	);

	////////////////////////////////////////////////////////////////////////////
	// Event gathering and enable masking

	always_comb begin
		events = 8'h00;
		events[BIT_START] = start_detect_i;
		events[BIT_GCALL] = general_call_i;
		events[BIT_TXRDY] = tx_ready_i;
		events[BIT_RXRDY] = rx_ready_i;
		events[BIT_ARDY] = access_ready;
		events[BIT_OWN] = own_address_i;
		events[BIT_NACK] = no_ack_i;
		events[BIT_ARB] = arb_lost_i;
	end

	// DMA servicing takes over the ready flags, so their enables are ignored
	always_comb begin
		eff_enable = state.enable;
		eff_enable[BIT_TXRDY] = state.enable[BIT_TXRDY] & ~state.tx_dma;
		eff_enable[BIT_RXRDY] = state.enable[BIT_RXRDY] & ~state.rx_dma;
	end

	assign wr_ctrl = wr_i && (addr_i == OFS_CONTROL);
	assign rd_vec = rd_i && (addr_i == OFS_VECTOR);

	////////////////////////////////////////////////////////////////////////////
	// Register update

	always_comb begin
		next_state = state;
		next_state.rdata = RDATA_RESET;
		next_eff_enable = 8'h00;
		if (wr_i) begin
			case (addr_i)
				OFS_TARGET: next_state.target_addr = wdata_i[TARGET_W-1:0];
				OFS_ENABLE: next_state.enable = wdata_i[7:0];
				OFS_FLAGS: next_state.flags = wdata_i[7:0];
				OFS_CONTROL: begin
					next_state.repeat_mode = wdata_i[CTL_REPEAT];
					next_state.tx_dma = wdata_i[CTL_TXDMA];
					next_state.rx_dma = wdata_i[CTL_RXDMA];
				end
				OFS_COUNT: next_state.byte_count = wdata_i[7:0];
				default: begin
				end
			endcase
		end
		// Stop request: the engine's completion clears it, a new write re-arms it
		if (state.stop_req && stop_done_i)
			next_state.stop_req = 1'b0;
		if (wr_ctrl && wdata_i[CTL_STOP])
			next_state.stop_req = 1'b1;
		// Reading the vector retires the source it reports
		if (rd_vec)
			next_state.flags = next_state.flags & ~vec_onehot;
		// Hardware events are applied last so a same-cycle clear never loses one
		next_state.flags = next_state.flags | events;
		if (rd_i) begin
			case (addr_i)
				OFS_TARGET: next_state.rdata = {6'h00, state.target_addr};
				OFS_ENABLE: next_state.rdata = {8'h00, state.enable};
				OFS_FLAGS: next_state.rdata = {8'h00, state.flags};
				OFS_VECTOR: next_state.rdata = {11'h000, vec_code, 1'b0};
				OFS_CONTROL: next_state.rdata = {12'h000, state.rx_dma, state.tx_dma,
					state.repeat_mode, state.stop_req};
				OFS_COUNT: next_state.rdata = {8'h00, state.byte_count};
				OFS_STATUS: next_state.rdata = {8'h00, bytes_moved};
				default: next_state.rdata = RDATA_RESET;
			endcase
		end
		// Interrupt follows the updated flags and controls
		next_eff_enable = next_state.enable;
		next_eff_enable[BIT_TXRDY] = next_state.enable[BIT_TXRDY] & ~next_state.tx_dma;
		next_eff_enable[BIT_RXRDY] = next_state.enable[BIT_RXRDY] & ~next_state.rx_dma;
		next_state.irq = |(next_state.flags & next_eff_enable);
		// Slave mode keeps the address off the engine entirely
		next_state.target_out = master_i ? next_state.target_addr : TARGET_RESET;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			state.target_addr <= TARGET_RESET;
			state.enable <= ENABLE_RESET;
			state.flags <= FLAGS_RESET;
			state.stop_req <= 1'b0;
			state.repeat_mode <= 1'b0;
			state.tx_dma <= 1'b0;
			state.rx_dma <= 1'b0;
			state.byte_count <= COUNT_RESET;
			state.rdata <= RDATA_RESET;
			state.irq <= 1'b0;
			state.target_out <= TARGET_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign rdata_o = state.rdata;
	assign irq_o = state.irq;
	assign stop_request_o = state.stop_req;
	assign target_address_o = state.target_out;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	sequence s_vector_read;
		rd_i && addr_i == OFS_VECTOR && vec_code != VEC_NONE;
	endsequence

	sequence s_stop_done;
		state.stop_req && stop_done_i && !(wr_ctrl && wdata_i[CTL_STOP]);
	endsequence

	a_addr_upper_zero: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		rd_i && addr_i == OFS_TARGET |=> rdata_o[15:10] == 6'h00
		&& rdata_o[9:0] == $past(state.target_addr))
		else $error("target address read back wrong");

	a_target_slave_off: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		!master_i |=> target_address_o == TARGET_RESET)
		else $error("target address driven in slave mode");

	a_enable_write: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		wr_i && addr_i == OFS_ENABLE |=> state.enable == $past(wdata_i[7:0]))
		else $error("enable register not written");

	a_tx_dma_block: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		state.tx_dma && !wr_i && events == 8'h00 && !rd_vec
		&& (state.flags & state.enable & ~(8'h01 << BIT_TXRDY)) == 8'h00 |=> !irq_o)
		else $error("transmit ready raised request under DMA");

	a_rx_dma_block: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		state.rx_dma && !wr_i && events == 8'h00 && !rd_vec
		&& (state.flags & state.enable & ~(8'h01 << BIT_RXRDY)) == 8'h00 |=> !irq_o)
		else $error("receive ready raised request under DMA");

	a_event_sets_flag: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		events != 8'h00 |=> (state.flags & $past(events)) == $past(events))
		else $error("hardware event lost");

	a_ardy_flag: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		access_ready |=> state.flags[BIT_ARDY])
		else $error("access ready flag not set");

	a_vector_code: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		rd_vec |=> rdata_o[15:5] == 11'h000 && rdata_o[0] == 1'b0
		&& (rdata_o == 16'h0000) == ($past(state.flags) == 8'h00))
		else $error("vector code malformed");

	a_stop_self_clear: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		s_stop_done |=> !stop_request_o)
		else $error("stop request did not clear");

	a_irq_follows: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		##1 irq_o == |($past(next_state.flags) & $past(next_eff_enable)))
		else $error("interrupt line disagrees with flags");

	a_vector_clears: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		s_vector_read ##0 (!wr_i && (events & vec_onehot) == 8'h00)
		|=> (state.flags & $past(vec_onehot)) == 8'h00)
		else $error("vector read did not retire its flag");
endmodule

// >>> test/host_model.sv
// Register bus master standing in for the host processor
module host_model
	import i2c_irq_pkg::*;
(
	// Clock
	input wire logic sys_clk_i,
	// Register port
	output logic [3:0] addr_o,
	output logic [15:0] wdata_o,
	output logic wr_o,
	output logic rd_o,
	input wire logic [15:0] rdata_i
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		addr_o = 4'h0;
		wdata_o = 16'h0000;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// Idle address and data are scrambled so nothing leans on stale values
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge sys_clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
		@(posedge sys_clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge sys_clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(negedge sys_clk_i);
		d = rdata_i;
	endtask
endmodule

// >>> test/i2c_interrupt_vector_logic_tb.sv
// Self-checking bench for the I2C interrupt, vector and target address block
module i2c_interrupt_vector_logic_tb;
	import i2c_irq_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [10:0] TXR = 11'h080;
	localparam logic [10:0] RXR = 11'h100;
	localparam logic [10:0] ARB = 11'h010;
	localparam logic [10:0] MST = 11'h008;
	localparam logic [10:0] BYT = 11'h004;
	localparam logic [10:0] SDN = 11'h002;
	localparam logic [10:0] SRX = 11'h001;
	logic sys_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [3:0] addr;
	logic [15:0] wdata;
	logic wr;
	logic rd;
	logic [15:0] rdata;
	logic [10:0] pls = 11'h000;
	logic rx_empty = 1'b1;
	logic master = 1'b0;
	logic transmit = 1'b0;
	logic [9:0] target;
	logic stop_req;
	logic irq;
	int error_cnt = 0;
	int n_checks = 0;
	initial begin
		forever #25 sys_clk_i = ~sys_clk_i;
	end
	host_model host (.sys_clk_i(sys_clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
		.rd_o(rd), .rdata_i(rdata));
	i2c_interrupt_vector_logic dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .start_detect_i(pls[10]),
		.general_call_i(pls[9]), .tx_ready_i(pls[7]), .rx_ready_i(pls[8]),
		.own_address_i(pls[6]), .no_ack_i(pls[5]), .arb_lost_i(pls[4]),
		.master_start_i(pls[3]), .byte_done_i(pls[2]), .stop_done_i(pls[1]),
		.stop_received_i(pls[0]), .rx_buffer_empty_i(rx_empty), .master_i(master),
		.transmit_i(transmit), .target_address_o(target), .stop_request_o(stop_req),
		.irq_o(irq));
	////////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
		logic [15:0] d;
		host.rd_reg(a, d);
		chk(d, exp);
	endtask
	task automatic ichk(input logic [15:0] exp);
		@(negedge sys_clk_i);
		chk({15'h0000, irq}, exp);
	endtask
	// Event pulses last one cycle; the settle time covers the access ready pipeline
	task automatic pulse(input logic [10:0] v);
		@(posedge sys_clk_i);
		pls <= v;
		@(posedge sys_clk_i);
		pls <= 11'h000;
		repeat (4) @(posedge sys_clk_i);
	endtask
	initial begin
		repeat (100000) @(posedge sys_clk_i);
		error_cnt++;
		end_sim();
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		rchk(OFS_ENABLE, 16'h0000);
		rchk(OFS_FLAGS, 16'h0000);
		rchk(OFS_VECTOR, 16'h0000);
		host.wr_reg(OFS_TARGET, 16'hffff);
		rchk(OFS_TARGET, 16'h03ff);
		chk({6'h00, target}, 16'h0000);
		master <= 1'b1;
		repeat (2) @(negedge sys_clk_i);
		chk({6'h00, target}, 16'h03ff);
		host.wr_reg(4'h7, 16'hffff);
		rchk(4'h7, 16'h0000);
		host.wr_reg(OFS_VECTOR, 16'hffff);
		rchk(OFS_VECTOR, 16'h0000);
		$display("test registers done");
		host.wr_reg(OFS_ENABLE, 16'hffff);
		rchk(OFS_ENABLE, 16'h00ff);
		host.wr_reg(OFS_FLAGS, 16'h00ff);
		ichk(16'h0001);
		for (int i = 1; i <= 8; i++) begin
			rchk(OFS_VECTOR, 16'(2 * i));
		end
		rchk(OFS_VECTOR, 16'h0000);
		chk(rdata, 16'h0000);
		ichk(16'h0000);
		$display("test vector done");
		host.wr_reg(OFS_ENABLE, 16'h0001);
		pulse(ARB);
		ichk(16'h0001);
		host.wr_reg(OFS_ENABLE, 16'h0000);
		ichk(16'h0000);
		host.wr_reg(OFS_FLAGS, 16'h0000);
		host.wr_reg(OFS_ENABLE, 16'h0030);
		host.wr_reg(OFS_CONTROL, 16'h0004);
		pulse(TXR);
		ichk(16'h0000);
		rchk(OFS_FLAGS, 16'h0020);
		host.wr_reg(OFS_CONTROL, 16'h0000);
		ichk(16'h0001);
		host.wr_reg(OFS_FLAGS, 16'h0000);
		host.wr_reg(OFS_CONTROL, 16'h0008);
		pulse(RXR);
		ichk(16'h0000);
		host.wr_reg(OFS_CONTROL, 16'h0000);
		ichk(16'h0001);
		host.wr_reg(OFS_FLAGS, 16'h0000);
		host.wr_reg(OFS_ENABLE, 16'h0000);
		$display("test masking done");
		transmit <= 1'b1;
		host.wr_reg(OFS_COUNT, 16'h0002);
		pulse(MST);
		pulse(BYT);
		rchk(OFS_FLAGS, 16'h0000);
		pulse(BYT);
		rchk(OFS_FLAGS, 16'h0008);
		rchk(OFS_STATUS, 16'h0002);
		host.wr_reg(OFS_FLAGS, 16'h0000);
		host.wr_reg(OFS_CONTROL, 16'h0002);
		pulse(BYT);
		rchk(OFS_FLAGS, 16'h0000);
		host.wr_reg(OFS_CONTROL, 16'h0003);
		@(negedge sys_clk_i);
		chk({15'h0000, stop_req}, 16'h0001);
		rchk(OFS_CONTROL, 16'h0003);
		pulse(BYT);
		rchk(OFS_FLAGS, 16'h0008);
		pulse(SDN);
		@(negedge sys_clk_i);
		chk({15'h0000, stop_req}, 16'h0000);
		$display("test master transmit done");
		host.wr_reg(OFS_FLAGS, 16'h0000);
		host.wr_reg(OFS_CONTROL, 16'h0000);
		host.wr_reg(OFS_COUNT, 16'h0001);
		transmit <= 1'b0;
		rx_empty <= 1'b0;
		pulse(MST);
		pulse(BYT);
		rchk(OFS_FLAGS, 16'h0000);
		rx_empty <= 1'b1;
		pulse(11'h000);
		rchk(OFS_FLAGS, 16'h0008);
		host.wr_reg(OFS_FLAGS, 16'h0000);
		host.wr_reg(OFS_CONTROL, 16'h0003);
		rx_empty <= 1'b0;
		pulse(BYT);
		rchk(OFS_FLAGS, 16'h0000);
		rx_empty <= 1'b1;
		pulse(SDN);
		rchk(OFS_FLAGS, 16'h0008);
		$display("test master receive done");
		host.wr_reg(OFS_FLAGS, 16'h0000);
		master <= 1'b0;
		transmit <= 1'b1;
		pulse(SRX);
		rchk(OFS_FLAGS, 16'h0008);
		host.wr_reg(OFS_FLAGS, 16'h0000);
		transmit <= 1'b0;
		rx_empty <= 1'b0;
		pulse(SRX);
		rchk(OFS_FLAGS, 16'h0000);
		rx_empty <= 1'b1;
		pulse(11'h000);
		rchk(OFS_FLAGS, 16'h0008);
		$display("test slave done");
		end_sim();
	end
endmodule
